// [test/brake_model.sv]
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Holding brake, builds torque over time once engaged
module brake_model #(
    parameter int ENGAGE_CYC = 16
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic release_i,
    output logic      holding_o
);
    int build;

    // Torque lost at once on release, regained gradually
    always_ff @(posedge clk_i) begin
        if (rst_i || release_i) begin
            build <= 0;
        end else if (build < ENGAGE_CYC) begin
            build <= build + 1;
        end
    end

    assign holding_o = (build >= ENGAGE_CYC);
endmodule // brake_model
`default_nettype wire

// [test/holding_brake_sequencer_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module holding_brake_sequencer_bench;
    localparam int B  = 5;
    localparam int P  = 4;
    localparam int SZ = 3;
    localparam int TZ = 2;
    localparam int H  = 1;
    localparam int G  = 0;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic        ack;
    logic        pin = 1'b0;
    logic        pos_mode = 1'b0;
    logic        request = 1'b0;
    logic        done = 1'b0;
    logic [15:0] speed = 16'h0000;
    logic [5:0]  outs;
    logic        holding;
    int          mismatches = 0;
    int          compares = 0;
    int          n;

    always #5 clk_i = ~clk_i;

    holding_brake_sequencer #(.SPEED_W(16)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .enable_pin_i(pin),
        .pos_mode_i(pos_mode), .pos_request_i(request), .move_done_i(done),
        .speed_i(speed), .brake_release_o(outs[B]), .power_enable_o(outs[P]),
        .speed_zero_o(outs[SZ]), .torque_zero_o(outs[TZ]),
        .hold_position_o(outs[H]), .move_go_o(outs[G])
    );

    brake_model #(.ENGAGE_CYC(16)) u_brake (
        .clk_i(clk_i), .rst_i(rst_i), .release_i(outs[B]), .holding_o(holding)
    );

    // =================================================================
    // Checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            mismatches++;
        end
    endtask

    task automatic check_rng(input int v, input int lo, input int hi);
        check({31'h0000_0000, (v >= lo && v <= hi)}, 32'h0000_0001);
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        tally_and_finish();
    end

    // =================================================================
    // Wishbone classic cycle
    task automatic wb_xfer(input logic w, input logic [5:0] a,
                           input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 50);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (k >= 50) begin
            check(32'h0000_0000, 32'h0000_0001);
        end
    endtask

    task automatic wb_wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb_xfer(1'b1, a, d, r);
    endtask

    task automatic wb_rd(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] r;
        wb_xfer(1'b0, a, 32'h0000_0000, r);
        check(r, exp);
    endtask

    // =================================================================
    // Output waits and input pulses
    task automatic wait_out(input int i, input logic v, output int k);
        k = 0;
        while (outs[i] !== v && k < 2000) begin
            @(negedge clk_i);
            k++;
        end
        if (k >= 2000) begin
            check(32'h0000_0000, 32'h0000_0001);
        end
    endtask

    task automatic pulse_done();
        @(posedge clk_i);
        done <= 1'b1;
        @(posedge clk_i);
        done <= 1'b0;
    endtask

    task automatic pulse_request();
        @(posedge clk_i);
        request <= 1'b1;
        @(posedge clk_i);
        request <= 1'b0;
    endtask

    // =================================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        check({26'h000_0000, outs}, 32'h0000_0000);
        wb_rd(6'h00, 32'h0000_0000);
        wb_rd(6'h04, 32'h0000_0000);
        wb_rd(6'h0c, 32'h0000_0000);
        wb_rd(6'h10, 32'h0000_0010);
        wb_rd(6'h18, 32'h0000_0000);
        wb_wr(6'h14, 32'hffff_ffff);
        wb_rd(6'h14, 32'h0000_0000);
        wb_wr(6'h04, 32'h0000_000a);
        wb_wr(6'h08, 32'h0000_0014);
        wb_wr(6'h0c, 32'h0000_001e);
        wb_rd(6'h08, 32'h0000_0014);
        // Enable through pin and software
        pin <= 1'b1;
        wb_wr(6'h00, 32'h0000_0001);
        wait_out(B, 1'b1, n);
        check({26'h000_0000, outs}, 32'h0000_0031);
        wb_rd(6'h14, 32'h0000_0389);
        // Disable while still moving
        @(posedge clk_i);
        speed <= 16'h0064;
        wb_wr(6'h00, 32'h0000_0000);
        wait_out(SZ, 1'b1, n);
        repeat (30) @(negedge clk_i);
        check({30'h0000_0000, outs[B], outs[P]}, 32'h0000_0003);
        @(posedge clk_i);
        speed <= 16'hfffb;
        wait_out(B, 1'b0, n);
        check({30'h0000_0000, outs[H], outs[P]}, 32'h0000_0003);
        wait_out(P, 1'b0, n);
        check_rng(n, 20, 24);
        check({31'h0000_0000, holding}, 32'h0000_0001);
        // Automatic brake outside positioning mode
        @(posedge clk_i);
        speed <= 16'h0000;
        wb_wr(6'h00, 32'h0000_0003);
        wait_out(B, 1'b1, n);
        pulse_done();
        repeat (40) @(negedge clk_i);
        check({31'h0000_0000, outs[B]}, 32'h0000_0001);
        // Request before idle time runs out
        @(posedge clk_i);
        pos_mode <= 1'b1;
        pulse_done();
        repeat (10) @(negedge clk_i);
        pulse_request();
        repeat (40) @(negedge clk_i);
        check({30'h0000_0000, outs[B], outs[G]}, 32'h0000_0003);
        // Idle timeout, stop delay, parked
        pulse_done();
        wait_out(B, 1'b0, n);
        check_rng(n, 29, 34);
        check({29'h0000_0000, outs[P], outs[TZ], outs[H]}, 32'h0000_0005);
        wait_out(TZ, 1'b1, n);
        check_rng(n, 20, 24);
        check({29'h0000_0000, outs[P], outs[B], holding}, 32'h0000_0005);
        repeat (20) @(negedge clk_i);
        check({30'h0000_0000, outs[P], outs[TZ]}, 32'h0000_0003);
        // Request wakes the parked axis
        pulse_request();
        wait_out(B, 1'b1, n);
        check_rng(n, 0, 4);
        check({30'h0000_0000, outs[TZ], outs[G]}, 32'h0000_0000);
        wait_out(G, 1'b1, n);
        check_rng(n, 9, 14);
        // Zero delays, auto brake left by mode, disable by pin
        wb_wr(6'h08, 32'h0000_0000);
        wb_wr(6'h04, 32'h0000_0000);
        pulse_done();
        wait_out(TZ, 1'b1, n);
        check_rng(n, 31, 36);
        pulse_request();
        wait_out(G, 1'b1, n);
        check_rng(n, 1, 3);
        pulse_done();
        @(posedge clk_i);
        pos_mode <= 1'b0;
        repeat (3) @(negedge clk_i);
        check({31'h0000_0000, outs[G]}, 32'h0000_0001);
        @(posedge clk_i);
        pin <= 1'b0;
        wait_out(B, 1'b0, n);
        wait_out(P, 1'b0, n);
        check_rng(n, 0, 2);
        wb_rd(6'h14, 32'h0000_0000);
        tally_and_finish();
    end
endmodule // holding_brake_sequencer_bench
`default_nettype wire

// [verilog/brake_defs.svh]
`ifndef BRAKE_DEFS_SVH
`define BRAKE_DEFS_SVH
// =====================================================================
// Register word indices
`define REG_CTRL        4'h0
`define REG_START_DLY   4'h1
`define REG_STOP_DLY    4'h2
`define REG_IDLE_TIME   4'h3
`define REG_SPEED_THR   4'h4
`define REG_STATUS      4'h5
`define REG_CMD_WIDTH   4
// =====================================================================
// Control register fields and register reset values
`define CTRL_ENABLE_BIT 0
`define CTRL_AUTO_BIT   1
`define CTRL_MASK       32'h0000_0003
`define CTRL_RESET      32'h0000_0000
`define DLY_RESET       32'h0000_0000
`define THR_RESET       32'h0000_0010
`endif

// [verilog/brake_pkg.sv]
package brake_pkg;
    // =================================================================
    // Sequencer states
    typedef enum logic [2:0] {
        st_off      = 3'b000,
        st_run      = 3'b001,
        st_ramp     = 3'b010,
        st_stop_dly = 3'b011,
        st_idle     = 3'b100,
        st_park_dly = 3'b101,
        st_parked   = 3'b110,
        st_start_dly= 3'b111
    } seq_state_e;

    // Drive side outputs
    typedef struct packed {
        logic brake_release;
        logic power_enable;
        logic speed_zero;
        logic torque_zero;
        logic hold_position;
        logic move_go;
    } drive_cmd_s;
endpackage

// [verilog/delay_timer.sv]
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Down counter, zero load finishes at once
module delay_timer #(
    parameter int WIDTH = 32
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] value_i,
    output logic                  done_o
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic             done;
    logic             next_done;

    if (WIDTH < 2) begin : g_width_check
        $error("delay_timer width too small");
    end

    always_comb begin
        next_count = count;
        next_done  = done;
        if (load_i) begin
            next_count = value_i;
            next_done  = (value_i == '0);
        end else if (count != '0) begin
            next_count = count - 1'b1;
            next_done  = (count == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= '0;
            done  <= 1'b0;
        end else begin
            count <= next_count;
            done  <= next_done;
        end
    end

    assign done_o = done;
endmodule // delay_timer
`default_nettype wire

// [verilog/holding_brake_sequencer.sv]
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "brake_defs.svh"
// Summary of operation
// - One output pin drives the holding brake
// - Enabled drive keeps brake released
// - Separate start and stop delay settings
// - Disable first forces speed setpoint zero, except when parked: straight to off
// - Near-zero speed engages brake, starts stop delay
// - Hold position; internal disable after delay
// - Automatic brake only in positioning mode
// - Time idle from move done to request
// - Idle timeout engages brake, starts stop delay
// - Automatic brake keeps enable and power stage
// - New request releases brake, enables torque; ignored during stop delay after idle
// - Start delay holds off positioning start
// - Stop delay after idle, holding position
// - After stop delay zero torque, stay enabled
module holding_brake_sequencer #(
    parameter int SPEED_W = 16
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [5:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic               enable_pin_i,
    input  wire logic               pos_mode_i,
    input  wire logic               pos_request_i,
    input  wire logic               move_done_i,
    input  wire logic [SPEED_W-1:0] speed_i,
    output logic                    brake_release_o,
    output logic                    power_enable_o,
    output logic                    speed_zero_o,
    output logic                    torque_zero_o,
    output logic                    hold_position_o,
    output logic                    move_go_o
);
    if (SPEED_W < 2 || SPEED_W > 32) begin : g_width_check
        $error("speed width out of range");
    end

    // =================================================================
    // Pin synchroniser
    logic [1:0] en_sync;
    logic [1:0] next_en_sync;
    logic       enable_req;

    always_comb begin
        next_en_sync = {en_sync[0], enable_pin_i};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_sync <= 2'b00;
        end else begin
            en_sync <= next_en_sync;
        end
    end

    // =================================================================
    // Wishbone registers
    logic [31:0] ctrl;
    logic [31:0] start_dly;
    logic [31:0] stop_dly;
    logic [31:0] idle_time;
    logic [31:0] speed_thr;
    logic [31:0] next_ctrl;
    logic [31:0] next_start_dly;
    logic [31:0] next_stop_dly;
    logic [31:0] next_idle_time;
    logic [31:0] next_speed_thr;
    logic [31:0] rd_data;
    logic [31:0] next_rd_data;
    logic        ack;
    logic        next_ack;
    logic        wr_en;
    logic [`REG_CMD_WIDTH-1:0] word_adr;
    brake_pkg::seq_state_e state;
    brake_pkg::seq_state_e next_state;
    brake_pkg::drive_cmd_s cmd;
    brake_pkg::drive_cmd_s next_cmd;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) res[i*8 +: 8] = data[i*8 +: 8];
        end
        return res;
    endfunction

    assign word_adr   = wb_adr_i[5:2];
    assign wr_en      = wb_cyc_i && wb_stb_i && wb_we_i && !ack;
    assign enable_req = en_sync[1] && ctrl[`CTRL_ENABLE_BIT];

    always_comb begin
        next_ctrl      = ctrl;
        next_start_dly = start_dly;
        next_stop_dly  = stop_dly;
        next_idle_time = idle_time;
        next_speed_thr = speed_thr;
        next_ack       = wb_cyc_i && wb_stb_i && !ack;
        next_rd_data   = 32'h0000_0000;
        if (wr_en) begin
            unique case (word_adr)
                `REG_CTRL:      next_ctrl      = merge(ctrl, wb_dat_i, wb_sel_i) & `CTRL_MASK;
                `REG_START_DLY: next_start_dly = merge(start_dly, wb_dat_i, wb_sel_i);
                `REG_STOP_DLY:  next_stop_dly  = merge(stop_dly, wb_dat_i, wb_sel_i);
                `REG_IDLE_TIME: next_idle_time = merge(idle_time, wb_dat_i, wb_sel_i);
                `REG_SPEED_THR: next_speed_thr = merge(speed_thr, wb_dat_i, wb_sel_i);
                default:        next_ctrl      = ctrl;
            endcase
        end
        unique case (word_adr)
            `REG_CTRL:      next_rd_data = ctrl;
            `REG_START_DLY: next_rd_data = start_dly;
            `REG_STOP_DLY:  next_rd_data = stop_dly;
            `REG_IDLE_TIME: next_rd_data = idle_time;
            `REG_SPEED_THR: next_rd_data = speed_thr;
            `REG_STATUS:    next_rd_data = {22'h00_0000, en_sync[1], cmd, state};
            default:        next_rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl      <= `CTRL_RESET;
            start_dly <= `DLY_RESET;
            stop_dly  <= `DLY_RESET;
            idle_time <= `DLY_RESET;
            speed_thr <= `THR_RESET;
            rd_data   <= 32'h0000_0000;
            ack       <= 1'b0;
        end else begin
            ctrl      <= next_ctrl;
            start_dly <= next_start_dly;
            stop_dly  <= next_stop_dly;
            idle_time <= next_idle_time;
            speed_thr <= next_speed_thr;
            rd_data   <= next_rd_data;
            ack       <= next_ack;
        end
    end

    assign wb_dat_o = rd_data;
    assign wb_ack_o = ack;

    // =================================================================
    // Speed magnitude test
    logic [SPEED_W-1:0] speed_mag;
    logic               near_zero;
    assign speed_mag = speed_i[SPEED_W-1] ? SPEED_W'(-speed_i) : speed_i;
    assign near_zero = 32'(speed_mag) < speed_thr;

    // =================================================================
    // Timer
    logic        tmr_load;
    logic [31:0] tmr_value;
    logic        tmr_done;

    delay_timer #(.WIDTH(32)) u_timer (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .load_i  (tmr_load),
        .value_i (tmr_value),
        .done_o  (tmr_done)
    );

    // =================================================================
    // Sequencer
    logic auto_on;
    assign auto_on = ctrl[`CTRL_AUTO_BIT] && pos_mode_i;

    always_comb begin
        next_state = state;
        tmr_load   = 1'b0;
        tmr_value  = 32'h0000_0000;
        unique case (state)
            brake_pkg::st_off: begin
                if (enable_req) begin
                    next_state = brake_pkg::st_run;
                end
            end
            brake_pkg::st_run: begin
                if (!enable_req) begin
                    next_state = brake_pkg::st_ramp;
                end else if (auto_on && move_done_i) begin
                    next_state = brake_pkg::st_idle;
                    tmr_load   = 1'b1;
                    tmr_value  = idle_time;
                end
            end
            brake_pkg::st_ramp: begin
                if (near_zero) begin
                    next_state = brake_pkg::st_stop_dly;
                    tmr_load   = 1'b1;
                    tmr_value  = stop_dly;
                end
            end
            brake_pkg::st_stop_dly: begin
                if (tmr_done && !tmr_load) begin
                    next_state = brake_pkg::st_off;
                end
            end
            brake_pkg::st_idle: begin
                if (!enable_req) begin
                    next_state = brake_pkg::st_ramp;
                end else if (pos_request_i || !auto_on) begin
                    next_state = brake_pkg::st_run;
                end else if (tmr_done) begin
                    next_state = brake_pkg::st_park_dly;
                    tmr_load   = 1'b1;
                    tmr_value  = stop_dly;
                end
            end
            brake_pkg::st_park_dly: begin
                if (!enable_req) begin
                    next_state = brake_pkg::st_stop_dly;
                end else if (tmr_done) begin
                    next_state = brake_pkg::st_parked;
                end
            end
            brake_pkg::st_parked: begin
                if (!enable_req) begin
                    next_state = brake_pkg::st_off;
                end else if (pos_request_i || !auto_on) begin
                    next_state = brake_pkg::st_start_dly;
                    tmr_load   = 1'b1;
                    tmr_value  = start_dly;
                end
            end
            brake_pkg::st_start_dly: begin
                if (!enable_req) begin
                    next_state = brake_pkg::st_ramp;
                end else if (tmr_done && !tmr_load) begin
                    next_state = brake_pkg::st_run;
                end
            end
        endcase
    end

    always_comb begin
        next_cmd = '0;
        unique case (next_state)
            brake_pkg::st_off: next_cmd = '0;
            brake_pkg::st_run: begin
                next_cmd.brake_release = 1'b1;
                next_cmd.power_enable  = 1'b1;
                next_cmd.move_go       = 1'b1;
            end
            brake_pkg::st_ramp: begin
                next_cmd.brake_release = 1'b1;
                next_cmd.power_enable  = 1'b1;
                next_cmd.speed_zero    = 1'b1;
            end
            brake_pkg::st_stop_dly: begin
                next_cmd.power_enable  = 1'b1;
                next_cmd.speed_zero    = 1'b1;
                next_cmd.hold_position = 1'b1;
            end
            brake_pkg::st_idle: begin
                next_cmd.brake_release = 1'b1;
                next_cmd.power_enable  = 1'b1;
                next_cmd.hold_position = 1'b1;
            end
            brake_pkg::st_park_dly: begin
                next_cmd.power_enable  = 1'b1;
                next_cmd.hold_position = 1'b1;
            end
            brake_pkg::st_parked: begin
                next_cmd.power_enable  = 1'b1;
                next_cmd.torque_zero   = 1'b1;
            end
            brake_pkg::st_start_dly: begin
                next_cmd.brake_release = 1'b1;
                next_cmd.power_enable  = 1'b1;
                next_cmd.hold_position = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= brake_pkg::st_off;
            cmd   <= '0;
        end else begin
            state <= next_state;
            cmd   <= next_cmd;
        end
    end

    assign brake_release_o = cmd.brake_release;
    assign power_enable_o  = cmd.power_enable;
    assign speed_zero_o    = cmd.speed_zero;
    assign torque_zero_o   = cmd.torque_zero;
    assign hold_position_o = cmd.hold_position;
    assign move_go_o       = cmd.move_go;

    // =================================================================
    // Checks
    property p_release_in_run;
        @(posedge clk_i) disable iff (rst_i)
        state == brake_pkg::st_run |-> brake_release_o;
    endproperty
    a_release_in_run: assert property (p_release_in_run)
        else $error("brake not released while running");

    property p_ramp_on_disable;
        @(posedge clk_i) disable iff (rst_i)
        (state == brake_pkg::st_run && !enable_req) |=> speed_zero_o && power_enable_o;
    endproperty
    a_ramp_on_disable: assert property (p_ramp_on_disable)
        else $error("disable did not zero speed first");

    property p_engage_at_zero;
        @(posedge clk_i) disable iff (rst_i)
        (state == brake_pkg::st_ramp && near_zero) |=> !brake_release_o && hold_position_o;
    endproperty
    a_engage_at_zero: assert property (p_engage_at_zero)
        else $error("brake not engaged at zero speed");

    property p_power_during_stop;
        @(posedge clk_i) disable iff (rst_i)
        state == brake_pkg::st_stop_dly |-> power_enable_o;
    endproperty
    a_power_during_stop: assert property (p_power_during_stop)
        else $error("power dropped during stop delay");

    property p_auto_only_pos;
        @(posedge clk_i) disable iff (rst_i)
        (state == brake_pkg::st_idle && !pos_mode_i && enable_req) |=> state == brake_pkg::st_run;
    endproperty
    a_auto_only_pos: assert property (p_auto_only_pos)
        else $error("automatic brake outside positioning mode");

    property p_parked_enabled;
        @(posedge clk_i) disable iff (rst_i)
        state == brake_pkg::st_parked |-> power_enable_o && torque_zero_o && !brake_release_o;
    endproperty
    a_parked_enabled: assert property (p_parked_enabled)
        else $error("parked outputs wrong");

    property p_request_releases;
        @(posedge clk_i) disable iff (rst_i)
        (state == brake_pkg::st_parked && enable_req && pos_request_i)
            |=> brake_release_o && !torque_zero_o;
    endproperty
    a_request_releases: assert property (p_request_releases)
        else $error("request did not release brake");

    property p_no_go_in_start;
        @(posedge clk_i) disable iff (rst_i)
        state == brake_pkg::st_start_dly |-> !move_go_o;
    endproperty
    a_no_go_in_start: assert property (p_no_go_in_start)
        else $error("move started during start delay");

    property p_zero_delay;
        @(posedge clk_i) disable iff (rst_i)
        (state == brake_pkg::st_parked && $rose(state == brake_pkg::st_start_dly) == 1'b0
         && enable_req && pos_request_i && start_dly == 32'h0000_0000)
            |=> ##[1:2] state == brake_pkg::st_run;
    endproperty
    a_zero_delay: assert property (p_zero_delay)
        else $error("zero start delay not immediate");
endmodule // holding_brake_sequencer
`default_nettype wire
